// file: rtl/gpmc_pkg.sv
// Constants and types shared by the power-mode controller
package gpmc_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ        = 50_000_000;
  localparam int unsigned STALL_MAX_US      = 4000;
  localparam int unsigned STALL_MAX_CYCLES  = (STALL_MAX_US / 1000) * (SYS_CLK_HZ / 1000);
  localparam int unsigned OSC_START_US      = 500;
  localparam int unsigned OSC_START_CYCLES  = OSC_START_US * (SYS_CLK_HZ / 1_000_000);
  localparam int unsigned CAL_CYCLES        = 64;

  // ------------------------------------------------------------
  // Measurement period defaults, in base ticks
  // ------------------------------------------------------------
  localparam logic [15:0] FULL_PERIOD_RST   = 16'h0001;
  localparam logic [15:0] SLEEP_PERIOD_RST  = 16'h0014;
  localparam logic [15:0] DEEP_PERIOD_RST   = 16'h0050;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS           = 8'h00;
  localparam logic [7:0] SLEEP_LEVEL_OFS    = 8'h04;
  localparam logic [7:0] DELAY_OFS          = 8'h08;
  localparam logic [7:0] STATUS_OFS         = 8'h0c;
  localparam logic [7:0] COMMAND_OFS        = 8'h10;
  localparam logic [7:0] PERIOD_OFS         = 8'h14;

  // Control register fields
  localparam int CTRL_SLEEP_EN_BIT          = 0;
  localparam int CTRL_WAKE_LEVEL_BIT        = 1;
  localparam int CTRL_WAKE_LO_BIT           = 2;
  localparam int CTRL_WAKE_HI_BIT           = 3;
  localparam logic [31:0] CTRL_RST          = 32'h0000_0000;
  localparam logic [15:0] SLEEP_LEVEL_RST   = 16'h0000;
  localparam logic [15:0] DELAY_RST         = 16'h0000;

  // Command register: write 1 to set the deep low-power flag
  localparam int CMD_SET_DEEP_BIT           = 0;

  // Status register fields
  localparam int STAT_MODE_LSB              = 0;
  localparam int STAT_DEEP_FLAG_BIT         = 4;
  localparam int STAT_HF_ON_BIT             = 5;
  localparam int STAT_WAKE_EN_BIT           = 6;
  localparam int STAT_STALL_BIT             = 7;
  localparam int STAT_COUNT_LSB             = 16;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ      = 2'b10;
  localparam logic [1:0] HTRANS_SEQ         = 2'b11;

  typedef enum logic [2:0] {
    GPMC_FULL     = 3'b000,
    GPMC_CAL      = 3'b001,
    GPMC_SLEEP    = 3'b010,
    GPMC_DEEP     = 3'b011,
    GPMC_RESTART  = 3'b100
  } gpmc_mode_t;

endpackage

// file: rtl/gpmc_tick_gen.sv
// Periodic one-cycle enable generator with programmable period
`timescale 1ns/100ps
module gpmc_tick_gen
  import gpmc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Control
  input  wire logic        run,
  input  wire logic [15:0] period,
  input  wire logic        baseTick,
  // Output
  output logic             tick
);

  logic [15:0] count;
  logic [15:0] next_count;
  logic        next_tick;

  always_comb
  begin
    next_count = count;
    next_tick  = 1'b0;
    if (!run)
    begin
      next_count = 16'h0000;
    end
    else if (baseTick)
    begin
      if (count + 16'h0001 >= period)
      begin
        next_count = 16'h0000;
        next_tick  = 1'b1;
      end
      else
      begin
        next_count = count + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule // gpmc_tick_gen

// file: rtl/gauge_power_mode_control.sv
// Power-mode controller: full activity, sleep and deep sleep, with AHB-Lite registers
//
// Behaviour
// - Three power modes, automatic moves on events, host may request some directly.
// - Full activity is the default mode; measures, refreshes data and decides moves.
// - Sleep entered only when sleep-enable is 1 and mean current below level.
// - Offset autocalibration runs after sleep qualifies and before sleep begins.
// - Sleep measures less often, still refreshes data periodically.
// - Sleep exits on mean current above level or wake comparator event.
// - Deep sleep stops the fast oscillator and measures least often.
// - Host command sets deep flag; enables deep sleep when delay equals 0.
// - Nonzero delay enables timed deep sleep; zero delay disables that method.
// - Flag method enters from sleep; timed method after countdown reaches 0.
// - Any host communication activity ends deep sleep.
// - In deep sleep the link may be held low up to 4 ms.
// - Deep sleep keeps sleep exit conditions: high current or wake event.
// - Three bits pick wake threshold; codes 000 and 001 disable the comparator.
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module gauge_power_mode_control
  import gpmc_pkg::*;
#(
  parameter int unsigned STALL_CYCLES   = STALL_MAX_CYCLES,
  parameter int unsigned RESTART_CYCLES = OSC_START_CYCLES
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Measurement and analog status
  input  wire logic [15:0] mean_current_reading,
  input  wire logic        wakeBreach,
  input  wire logic        calDone,
  input  wire logic        baseTick,
  // Host link activity
  input  wire logic        commActivity,
  input  wire logic        commServed,
  input  wire logic        commLineIn,
  // Outputs to analog and measurement logic
  output logic             hfOscEnable,
  output logic             calStart,
  output logic             measureTick,
  output logic             wakeCompEnable,
  output logic [2:0]       wakeThresholdSel,
  output logic [2:0]       powerMode,
  // Link line hold, open-drain; enable low while driving
  output logic             commLineOut,
  output logic             commLineOe_n
);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [3:0]  ctrl;
  logic [15:0] sleepLevel;
  logic [15:0] deep_low_power_delay;
  logic        deep_low_power_flag;
  logic [15:0] fullPeriod;
  logic [15:0] sleepPeriod;
  logic [15:0] deepPeriod;
  logic [3:0]  next_ctrl;
  logic [15:0] next_sleepLevel;
  logic [15:0] next_deep_low_power_delay;
  logic [15:0] next_fullPeriod;
  logic [15:0] next_sleepPeriod;
  logic [15:0] next_deepPeriod;

  // Bus address phase capture
  logic        wrPend;
  logic        rdPend;
  logic [7:0]  addrLatch;
  logic        next_wrPend;
  logic        next_rdPend;
  logic [7:0]  next_addrLatch;
  logic [31:0] next_hrdata;

  logic        busValid;
  logic        wrStrobe;
  logic        set_deep_low_power_command;

  // ------------------------------------------------------------
  // Mode machine state
  // ------------------------------------------------------------
  gpmc_mode_t  mode;
  gpmc_mode_t  next_mode;
  logic [15:0] delayCount;
  logic [15:0] next_delayCount;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic        next_deep_low_power_flag;
  logic        next_calStart;
  logic        next_holdLine;
  logic        holdLine;

  logic        sleepEnable;
  logic        currentLow;
  logic        wakeEvent;
  logic        exitCond;
  logic        flagMethod;
  logic        timedMethod;
  logic [15:0] period;
  logic        measRun;

  // ------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign busValid  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign wrStrobe  = wrPend;
  assign set_deep_low_power_command = wrStrobe && (addrLatch == COMMAND_OFS)
                                      && hwdata[CMD_SET_DEEP_BIT];

  always_comb
  begin
    next_wrPend    = 1'b0;
    next_rdPend    = 1'b0;
    next_addrLatch = addrLatch;
    next_hrdata    = hrdata;
    if (busValid)
    begin
      next_wrPend    = hwrite;
      next_rdPend    = !hwrite;
      next_addrLatch = {haddr[7:2], 2'b00};
      // Read data is formed at the address phase so it stands for the whole data phase
      case ({haddr[7:2], 2'b00})
        CTRL_OFS:        next_hrdata = {28'h0000000, ctrl};
        SLEEP_LEVEL_OFS: next_hrdata = {16'h0000, sleepLevel};
        DELAY_OFS:       next_hrdata = {16'h0000, deep_low_power_delay};
        STATUS_OFS:      next_hrdata = {delayCount, 8'h00, holdLine, wakeCompEnable,
                                        hfOscEnable, deep_low_power_flag, 1'b0, mode};
        PERIOD_OFS:      next_hrdata = {8'h00, deepPeriod[7:0], sleepPeriod[7:0],
                                        fullPeriod[7:0]};
        default:         next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    next_ctrl                 = ctrl;
    next_sleepLevel           = sleepLevel;
    next_deep_low_power_delay = deep_low_power_delay;
    next_fullPeriod           = fullPeriod;
    next_sleepPeriod          = sleepPeriod;
    next_deepPeriod           = deepPeriod;
    if (wrStrobe)
    begin
      case (addrLatch)
        CTRL_OFS:        next_ctrl = hwdata[3:0];
        SLEEP_LEVEL_OFS: next_sleepLevel = hwdata[15:0];
        DELAY_OFS:       next_deep_low_power_delay = hwdata[15:0];
        PERIOD_OFS:
        begin
          next_fullPeriod  = {8'h00, hwdata[7:0]};
          next_sleepPeriod = {8'h00, hwdata[15:8]};
          next_deepPeriod  = {8'h00, hwdata[23:16]};
        end
        default:         next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPend               <= 1'b0;
      rdPend               <= 1'b0;
      addrLatch            <= 8'h00;
      hrdata               <= 32'h0000_0000;
      ctrl                 <= CTRL_RST[3:0];
      sleepLevel           <= SLEEP_LEVEL_RST;
      deep_low_power_delay <= DELAY_RST;
      fullPeriod           <= FULL_PERIOD_RST;
      sleepPeriod          <= SLEEP_PERIOD_RST;
      deepPeriod           <= DEEP_PERIOD_RST;
    end
    else
    begin
      wrPend               <= next_wrPend;
      rdPend               <= next_rdPend;
      addrLatch            <= next_addrLatch;
      hrdata               <= next_hrdata;
      ctrl                 <= next_ctrl;
      sleepLevel           <= next_sleepLevel;
      deep_low_power_delay <= next_deep_low_power_delay;
      fullPeriod           <= next_fullPeriod;
      sleepPeriod          <= next_sleepPeriod;
      deepPeriod           <= next_deepPeriod;
    end
  end

  // ------------------------------------------------------------
  // Entry and exit conditions
  // ------------------------------------------------------------
  assign sleepEnable = ctrl[CTRL_SLEEP_EN_BIT];
  assign currentLow  = mean_current_reading < sleepLevel;
  // Codes 000 and 001 leave the comparator off
  assign wakeCompEnable   = ctrl[CTRL_WAKE_HI_BIT] | ctrl[CTRL_WAKE_LO_BIT];
  assign wakeThresholdSel = {ctrl[CTRL_WAKE_HI_BIT], ctrl[CTRL_WAKE_LO_BIT],
                             ctrl[CTRL_WAKE_LEVEL_BIT]};
  assign wakeEvent   = wakeCompEnable && wakeBreach;
  assign exitCond    = !sleepEnable || !currentLow || wakeEvent;
  assign flagMethod  = deep_low_power_flag && (deep_low_power_delay == 16'h0000);
  assign timedMethod = deep_low_power_delay != 16'h0000;

  // ------------------------------------------------------------
  // Mode sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    next_mode                = mode;
    next_delayCount          = delayCount;
    next_timer               = timer;
    next_calStart            = 1'b0;
    next_holdLine            = 1'b0;
    // The host command wins over any clear in the same cycle
    next_deep_low_power_flag = deep_low_power_flag;
    case (mode)
      GPMC_FULL:
      begin
        if (sleepEnable && currentLow && !wakeEvent)
        begin
          next_mode     = GPMC_CAL;
          next_calStart = 1'b1;
        end
      end
      GPMC_CAL:
      begin
        if (exitCond)
        begin
          next_mode = GPMC_FULL;
        end
        else if (calDone)
        begin
          next_mode = GPMC_SLEEP;
          next_delayCount = deep_low_power_delay;
        end
      end
      GPMC_SLEEP:
      begin
        if (exitCond)
        begin
          next_mode       = GPMC_FULL;
          next_delayCount = 16'h0000;
        end
        else if (flagMethod)
        begin
          next_mode  = GPMC_DEEP;
          next_timer = 32'h0000_0000;
        end
        else if (timedMethod)
        begin
          if (delayCount == 16'h0000)
          begin
            next_mode  = GPMC_DEEP;
            next_timer = 32'h0000_0000;
          end
          else if (baseTick)
          begin
            next_delayCount = delayCount - 16'h0001;
          end
        end
      end
      GPMC_DEEP:
      begin
        if (exitCond)
        begin
          next_mode                = GPMC_FULL;
          next_delayCount          = 16'h0000;
          next_deep_low_power_flag = 1'b0;
        end
        else if (commActivity)
        begin
          // Stall the line while the fast oscillator comes back
          next_mode                = GPMC_RESTART;
          next_timer               = 32'h0000_0000;
          next_holdLine            = 1'b1;
          next_deep_low_power_flag = 1'b0;
        end
      end
      GPMC_RESTART:
      begin
        next_timer    = timer + 32'h0000_0001;
        // Release at the first of: host served, stall limit; back to sleep once released and oscillator settled
        next_holdLine = holdLine && !commServed && (timer + 32'h1 < STALL_CYCLES);
        if (timer + 32'h0000_0001 >= RESTART_CYCLES && !next_holdLine)
        begin
          next_mode       = GPMC_SLEEP;
          next_delayCount = deep_low_power_delay;
        end
      end
      default:
      begin
        next_mode = GPMC_FULL;
      end
    endcase
    if (set_deep_low_power_command)
    begin
      next_deep_low_power_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode                <= GPMC_FULL;
      delayCount          <= 16'h0000;
      timer               <= 32'h0000_0000;
      calStart            <= 1'b0;
      holdLine            <= 1'b0;
      deep_low_power_flag <= 1'b0;
    end
    else
    begin
      mode                <= next_mode;
      delayCount          <= next_delayCount;
      timer               <= next_timer;
      calStart            <= next_calStart;
      holdLine            <= next_holdLine;
      deep_low_power_flag <= next_deep_low_power_flag;
    end
  end

  // ------------------------------------------------------------
  // Outputs and measurement rate
  // ------------------------------------------------------------
  assign powerMode    = mode;
  assign hfOscEnable  = (mode != GPMC_DEEP);
  assign commLineOut  = 1'b0;
  assign commLineOe_n = !holdLine;
  assign measRun      = (mode != GPMC_CAL) && (mode != GPMC_RESTART);

  always_comb
  begin
    case (mode)
      GPMC_SLEEP: period = sleepPeriod;
      GPMC_DEEP:  period = deepPeriod;
      default:    period = fullPeriod;
    endcase
  end

  gpmc_tick_gen u_meas_tick (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .run      (measRun),
    .period   (period),
    .baseTick (baseTick),
    .tick     (measureTick)
  );

endmodule // gauge_power_mode_control

// file: tb/gpmc_checker.sv
// Port-level assertions for the power-mode controller
`timescale 1ns/100ps
module gpmc_checker
  import gpmc_pkg::*;
#(
  parameter int unsigned STALL_CYCLES = 50
)
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // Bus, snooped for sleep settings
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // Inputs and outputs watched
  input wire logic [15:0] mean_current_reading,
  input wire logic        wakeBreach,
  input wire logic        commActivity,
  input wire logic        hfOscEnable,
  input wire logic        calStart,
  input wire logic        wakeCompEnable,
  input wire logic [2:0]  wakeThresholdSel,
  input wire logic [2:0]  powerMode,
  input wire logic        commLineOut,
  input wire logic        commLineOe_n
);
  logic        wrPend;
  logic [7:0]  wrOfs;
  logic        sleepEn;
  logic [15:0] sleepLvl;
  int unsigned holdCnt;
  logic        wakeHit;
  logic        curHigh;

  assign wakeHit = wakeBreach && wakeCompEnable;
  assign curHigh = mean_current_reading > sleepLvl;

  // ------------------------------------------------------------
  // Shadow of sleep settings; register writes land at data-phase end
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPend   <= 1'b0;
      wrOfs    <= 8'h00;
      sleepEn  <= 1'b0;
      sleepLvl <= 16'h0000;
      holdCnt  <= 0;
    end
    else
    begin
      wrPend  <= hsel && hready && htrans[1] && hwrite;
      wrOfs   <= haddr[7:0];
      holdCnt <= commLineOe_n ? 0 : holdCnt + 1;
      if (wrPend && wrOfs == CTRL_OFS)
        sleepEn <= hwdata[CTRL_SLEEP_EN_BIT];
      if (wrPend && wrOfs == SLEEP_LEVEL_OFS)
        sleepLvl <= hwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_hf_osc_deep: assert property (hfOscEnable == (powerMode != GPMC_DEEP))
    else $error("fast oscillator enable does not follow deep mode");
  a_wake_code_map: assert property (wakeCompEnable == (wakeThresholdSel[2:1] != 2'b00))
    else $error("wake comparator enable wrong for code");
  a_cal_qualify: assert property ((powerMode == GPMC_CAL && $past(powerMode) == GPMC_FULL)
    |-> $past(sleepEn && mean_current_reading < sleepLvl))
    else $error("calibration entered without sleep qualification");
  a_cal_start_pulse: assert property ((powerMode == GPMC_CAL && $past(powerMode) != GPMC_CAL)
    |-> (calStart || $past(calStart)) or ##1 calStart)
    else $error("no calibration start around calibration entry");
  a_sleep_via_cal: assert property (powerMode == GPMC_SLEEP
    |-> $past(powerMode) inside {GPMC_CAL, GPMC_SLEEP, GPMC_RESTART})
    else $error("sleep entered without calibration");
  a_sleep_exit: assert property ((powerMode == GPMC_SLEEP && (curHigh || wakeHit))
    |=> powerMode == GPMC_FULL)
    else $error("sleep not left on exit condition");
  a_deep_exit: assert property ((powerMode == GPMC_DEEP && (curHigh || wakeHit))
    |=> powerMode == GPMC_FULL)
    else $error("deep sleep not left on exit condition");
  a_comm_wake: assert property ((powerMode == GPMC_DEEP && commActivity && sleepEn
    && mean_current_reading < sleepLvl && !wakeHit) |=> powerMode == GPMC_RESTART)
    else $error("link activity did not end deep sleep");
  a_restart_to_sleep: assert property (($past(powerMode) == GPMC_RESTART
    && powerMode != GPMC_RESTART) |-> powerMode == GPMC_SLEEP)
    else $error("restart did not return to sleep");
  a_hold_bound: assert property (holdCnt <= STALL_CYCLES)
    else $error("link line held low too long");
  a_hold_in_restart: assert property (!commLineOe_n |-> !commLineOut
    && powerMode == GPMC_RESTART)
    else $error("link line held outside restart");

  c_cal_sleep: cover property (powerMode == GPMC_CAL ##1 powerMode == GPMC_SLEEP);
  c_deep: cover property (powerMode == GPMC_DEEP);
  c_hold: cover property (!commLineOe_n);
endmodule // gpmc_checker

bind gauge_power_mode_control gpmc_checker #(.STALL_CYCLES(STALL_CYCLES)) uChk (.*);

// file: tb/gpmc_host_model.sv
// Host processor on the link: makes activity, waits out a line stall
`timescale 1ns/100ps
module gpmc_host_model
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Bench control
  input  wire logic        go,
  input  wire logic [15:0] serveDelay,
  output logic             busy,
  // Link
  input  wire logic        commLineOut,
  input  wire logic        commLineOe_n,
  output logic             commActivity,
  output logic             commServed,
  output logic             commLineIn
);
  logic [15:0] cnt;

  // Line has a pull-up, so a released line reads high
  assign commLineIn = commLineOe_n ? 1'b1 : commLineOut;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy         <= 1'b0;
      cnt          <= 16'h0000;
      commActivity <= 1'b0;
      commServed   <= 1'b0;
    end
    else
    begin
      commActivity <= go && !busy;
      if (go && !busy)
      begin
        busy <= 1'b1;
        cnt  <= serveDelay;
      end
      else if (busy)
      begin
        if (cnt != 16'h0000)
          cnt <= cnt - 16'h0001;
        commServed <= cnt == 16'h0000;
        // Transfer resumes only once the line is free again
        if (commServed && commLineIn)
        begin
          busy       <= 1'b0;
          commServed <= 1'b0;
        end
      end
    end
  end
endmodule // gpmc_host_model

// file: tb/testbench.sv
// Self-checking bench for the power-mode controller
`timescale 1ns/100ps
module testbench
  import gpmc_pkg::*;
;
  logic        sys_clk, nrst, hsel, hwrite, hready, wakeBreach, calDone, baseTick, go;
  logic        hreadyout, hresp, hfOscEnable, calStart, measureTick, wakeCompEnable;
  logic        commActivity, commServed, commLineIn, commLineOut, commLineOe_n, busy, calAuto;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] mean_current_reading, lvl, serveDelay;
  logic [2:0]  hsize, wakeThresholdSel, powerMode;
  logic [1:0]  htrans, tk;
  int          n_fail, total_checks, cf, cs, cd;

  assign hready = hreadyout;
  gauge_power_mode_control #(.STALL_CYCLES(50), .RESTART_CYCLES(20)) DUT (.*);
  gpmc_host_model uHost (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    tk       <= tk + 2'd1;
    baseTick <= tk == 2'd3;
    calDone  <= calAuto && powerMode == GPMC_CAL;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic waitRdy();
    int i;
    i = 0;
    while (hready !== 1'b1 && i < 50)
    begin
      @(posedge sys_clk);
      i++;
    end
    if (i == 50)
    begin
      n_fail++;
      summarize();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    @(posedge sys_clk);
    waitRdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    waitRdy();
    rd = hrdata;
    @(negedge sys_clk);
  endtask

  task automatic waitMode(input logic [2:0] m);
    int i;
    i = 0;
    while (powerMode !== m && i < 2000)
    begin
      @(negedge sys_clk);
      i++;
    end
    chk(32'(powerMode), 32'(m));
    if (powerMode !== m)
      summarize();
  endtask

  task automatic setCur(input logic [15:0] v);
    @(posedge sys_clk) mean_current_reading <= v;
  endtask

  task automatic ticks(output int c);
    c = 0;
    repeat (400) @(negedge sys_clk) c += int'(measureTick);
  endtask

  task automatic holdMode(input logic [2:0] m);
    repeat (40) @(negedge sys_clk);
    chk(32'(powerMode), 32'(m));
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {nrst, hsel, hwrite, wakeBreach, go, tk, baseTick, calDone} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'b010;
    calAuto = 1'b1;
    serveDelay = 16'd5;
    mean_current_reading = 16'hffff;
    n_fail = 0;
    total_checks = 0;
    rd = $urandom(46);
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    ahb(0, STATUS_OFS, 0);
    chk(rd & 32'hff, 32'h20);
    ahb(0, PERIOD_OFS, 0);
    chk(rd, 32'h0050_1401);
    ahb(0, 8'h40, 0);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
    ticks(cf);
    $display("reset test done");
    for (int c = 0; c < 8; c++)
    begin
      ahb(1, CTRL_OFS, 32'(c) << 1);
      chk(32'(wakeThresholdSel), 32'(c));
      chk(32'(wakeCompEnable), 32'(c > 1));
    end
    $display("wake code test done");
    lvl = 16'h1000 + 16'($urandom % 32768);
    ahb(1, SLEEP_LEVEL_OFS, {16'h0, lvl});
    setCur(lvl - 16'd1);
    ahb(1, CTRL_OFS, 32'h0);
    holdMode(GPMC_FULL);
    setCur(lvl);
    ahb(1, CTRL_OFS, 32'h1);
    holdMode(GPMC_FULL);
    calAuto = 1'b0;
    setCur(lvl - 16'(1 + $urandom % 64));
    waitMode(GPMC_CAL);
    holdMode(GPMC_CAL);
    calAuto = 1'b1;
    waitMode(GPMC_SLEEP);
    ticks(cs);
    chk(32'(cs < cf), 32'h1);
    setCur(lvl + 16'(1 + $urandom % 64));
    waitMode(GPMC_FULL);
    ahb(1, CTRL_OFS, 32'h5);
    setCur(lvl - 16'd1);
    waitMode(GPMC_SLEEP);
    @(posedge sys_clk) wakeBreach <= 1'b1;
    waitMode(GPMC_FULL);
    ahb(1, CTRL_OFS, 32'h3);
    waitMode(GPMC_SLEEP);
    holdMode(GPMC_SLEEP);
    @(posedge sys_clk) wakeBreach <= 1'b0;
    $display("sleep test done");
    setCur(16'hffff);
    waitMode(GPMC_FULL);
    ahb(1, COMMAND_OFS, 32'h1);
    ahb(0, STATUS_OFS, 0);
    chk(rd & 32'h17, 32'h10);
    holdMode(GPMC_FULL);
    setCur(lvl - 16'd1);
    waitMode(GPMC_DEEP);
    chk(32'(hfOscEnable), 32'h0);
    ticks(cd);
    chk(32'(cd < cs), 32'h1);
    setCur(lvl + 16'd1);
    waitMode(GPMC_FULL);
    ahb(0, STATUS_OFS, 0);
    chk(rd & 32'h10, 32'h0);
    $display("deep flag test done");
    ahb(1, COMMAND_OFS, 32'h1);
    setCur(lvl - 16'd1);
    waitMode(GPMC_DEEP);
    @(posedge sys_clk) go <= 1'b1;
    @(posedge sys_clk) go <= 1'b0;
    waitMode(GPMC_RESTART);
    @(negedge sys_clk);
    chk(32'(commLineIn), 32'h0);
    waitMode(GPMC_SLEEP);
    holdMode(GPMC_SLEEP);
    ahb(1, COMMAND_OFS, 32'h1);
    waitMode(GPMC_DEEP);
    serveDelay = 16'd200;
    @(posedge sys_clk) go <= 1'b1;
    @(posedge sys_clk) go <= 1'b0;
    waitMode(GPMC_RESTART);
    waitMode(GPMC_SLEEP);
    $display("link wake test done");
    setCur(16'hffff);
    waitMode(GPMC_FULL);
    ahb(1, DELAY_OFS, 32'd1000);
    setCur(lvl - 16'd1);
    waitMode(GPMC_SLEEP);
    ahb(0, STATUS_OFS, 0);
    chk(32'(rd[31:16] != 16'h0), 32'h1);
    setCur(16'hffff);
    waitMode(GPMC_FULL);
    ahb(0, STATUS_OFS, 0);
    chk(rd >> 16, 32'h0);
    ahb(1, DELAY_OFS, 32'd3);
    setCur(lvl - 16'd1);
    waitMode(GPMC_DEEP);
    setCur(16'hffff);
    waitMode(GPMC_FULL);
    ahb(1, DELAY_OFS, 32'd0);
    setCur(lvl - 16'd1);
    waitMode(GPMC_SLEEP);
    holdMode(GPMC_SLEEP);
    $display("timed test done");
    summarize();
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    summarize();
  end
endmodule // testbench
